// *** psec_pkg.sv ***
// Constants and types of the path error second classifier
// Functional notes
// - Near SES caused by near defect freezes all far-end counters that second
// - Near SES from errored-block threshold alone keeps far-end counting going
// - Lower-order paths use lower RDI, higher-order paths higher RDI
// - Aggregate mode counts each parity violation as one errored block
// - Second is errored on any anomaly block or listed defect
// - Second is severe when blocks reach threshold or any listed defect occurs
// - Threshold 600 for small containers, 2400 for large containers
// - Errored blocks outside a severe second count as background errors
// - Remote error indications are far-end anomalies for ES, SES, BBE
// - Remote defect indications make the second a far-end severe second
// - At 51 Mbit/s each OAM cell covers one block of 15 cells
// - At 155/622 Mbit/s each OAM cell covers 8 blocks of 27/54 cells
// - Any failing parity bit errors the block; one check one block
// - Cell anomalies: payload parity, header, OAM header, OAM loss or error
// - OAM cell lost after 14, 215 or 431 cells without a valid one
// - A block with several anomalies counts as one errored block
// - OAM loss or error marks all covered blocks errored
// - Cell defects: two OAM losses, path AIS, delineation loss, signal loss
// - Listed near-end path defects make a near-end severe second
// - Each path parity check covers one block, errored on any bit fail
// - Counts clear at the start of each measurement period
package psec_pkg;
   // ===========================================================
   // Thresholds and block geometry
   localparam logic [15:0] SES_THR_LOW   = 16'd600;
   localparam logic [15:0] SES_THR_HIGH  = 16'd2400;
   localparam logic [15:0] SES_THR_C51   = 16'd2445;
   localparam logic [15:0] SES_THR_C155  = 16'd4075;
   localparam logic [15:0] SES_THR_C622  = 16'd8151;
   localparam logic [5:0]  CPB_51        = 6'd15;
   localparam logic [5:0]  CPB_155       = 6'd27;
   localparam logic [5:0]  CPB_622       = 6'd54;
   localparam logic [3:0]  NBLK_ONE      = 4'd1;
   localparam logic [3:0]  NBLK_MULTI    = 4'd8;
   localparam logic [8:0]  OAM_X_51      = 9'd14;
   localparam logic [8:0]  OAM_X_155     = 9'd215;
   localparam logic [8:0]  OAM_X_622     = 9'd431;
   localparam logic [7:0]  BIP2_MASK     = 8'h03;
   localparam logic [7:0]  BIP8_MASK     = 8'hff;
   localparam logic [15:0] EB_MAX        = 16'hffff;
   localparam logic [31:0] CNT_RST       = 32'h0;
   // ===========================================================
   // Near-end defect vector positions
   localparam int ND_UNEQ = 0;
   localparam int ND_TIM  = 1;
   localparam int ND_LOP  = 2;
   localparam int ND_AIS  = 3;
   localparam int ND_LOM  = 4;
   localparam int ND_PLM  = 5;
   localparam logic [5:0] ND_LO_MASK = 6'h0f;
   localparam logic [5:0] ND_HI_MASK = 6'h3f;
   // ===========================================================
   // Configuration types
   typedef enum logic [2:0] {
      VC11 = 3'h0, VC12 = 3'h1, VC2 = 3'h2, VC25C = 3'h3,
      VC3 = 3'h4, VC4 = 3'h5, VC44C = 3'h6
   } psec_vc_type;
   typedef enum logic [1:0] {
      R51 = 2'h0, R155 = 2'h1, R622 = 2'h2
   } psec_rate_type;
endpackage : psec_pkg

// *** psec_class_if.sv ***
// Interface between the path monitor and one second classifier
`timescale 1ns/1ps
`default_nettype none
interface psec_class_if;
   logic        tick;
   logic        clear;
   logic        hold;
   logic        defect;
   logic [15:0] thr;
   logic [3:0]  eb_inc;
   logic        def_now;
   logic        es_p;
   logic        ses_p;
   logic [31:0] c_es;
   logic [31:0] c_ses;
   logic [31:0] c_bbe;
   modport cls (input tick, clear, hold, defect, thr, eb_inc,
                output def_now, es_p, ses_p, c_es, c_ses, c_bbe);
   modport ctl (output tick, clear, hold, defect, thr, eb_inc,
                input def_now, es_p, ses_p, c_es, c_ses, c_bbe);
endinterface : psec_class_if
`default_nettype wire

// *** psec_class.sv ***
// Per-second ES, SES and BBE classifier for one end of the path
`timescale 1ns/1ps
`default_nettype none
module psec_class
   import psec_pkg::*;
(
   input wire logic   mclk,
   input wire logic   rst_n,
   psec_class_if.cls  ci
);
   typedef struct packed {
      logic [15:0] eb;
      logic        def_seen;
      logic        es_p;
      logic        ses_p;
      logic [31:0] c_es;
      logic [31:0] c_ses;
      logic [31:0] c_bbe;
   } psec_cls_st_type;

   psec_cls_st_type st_reg;
   psec_cls_st_type st_next;
   logic [16:0]     eb_wide;
   logic [15:0]     eb_sum;
   logic            es_cond;
   logic            ses_cond;
   logic            count_en;

   // ===========================================================
   // Second accumulation and classification
   assign eb_wide  = {1'b0, st_reg.eb} + {13'h0, ci.eb_inc};
   assign eb_sum   = eb_wide[16] ? EB_MAX : eb_wide[15:0];
   assign ci.def_now = st_reg.def_seen | ci.defect;
   assign es_cond  = (eb_sum != 16'h0) | ci.def_now;
   assign ses_cond = (eb_sum >= ci.thr) | ci.def_now;
   assign count_en = ci.tick & ~ci.hold & ~ci.clear;

   always_comb begin
      st_next = st_reg;
      st_next.es_p  = 1'b0;
      st_next.ses_p = 1'b0;
      if (ci.tick) begin
         st_next.eb       = 16'h0;
         st_next.def_seen = 1'b0;
         if (count_en) begin
            st_next.es_p  = es_cond;
            st_next.ses_p = ses_cond;
            st_next.c_es  = st_reg.c_es + {31'h0, es_cond};
            st_next.c_ses = st_reg.c_ses + {31'h0, ses_cond};
            if (!ses_cond) begin
               st_next.c_bbe = st_reg.c_bbe + {16'h0, eb_sum};
            end
         end
      end else begin
         st_next.eb       = eb_sum;
         st_next.def_seen = ci.def_now;
      end
      if (ci.clear) begin
         st_next.c_es  = CNT_RST;
         st_next.c_ses = CNT_RST;
         st_next.c_bbe = CNT_RST;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign ci.es_p  = st_reg.es_p;
   assign ci.ses_p = st_reg.ses_p;
   assign ci.c_es  = st_reg.c_es;
   assign ci.c_ses = st_reg.c_ses;
   assign ci.c_bbe = st_reg.c_bbe;

   // ===========================================================
   // Checks
   es_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
      count_en && es_cond |=> ci.es_p && ci.c_es == $past(ci.c_es) + 32'd1)
      else $error("errored second not flagged");
   ses_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
      count_en && ci.def_now |=> ci.ses_p
         && ci.c_ses == $past(ci.c_ses) + 32'd1)
      else $error("defect second not severe");
   bbe_sum_a: assert property (@(posedge mclk) disable iff (!rst_n)
      count_en && !ses_cond |=>
         ci.c_bbe == $past(ci.c_bbe) + {16'h0, $past(eb_sum)})
      else $error("background errors miscounted");
   hold_freeze_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ci.tick && ci.hold && !ci.clear |=> $stable(ci.c_es)
         && $stable(ci.c_ses) && $stable(ci.c_bbe) && !ci.es_p)
      else $error("held counters changed");
   period_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ci.clear |=> ci.c_es == 32'h0 && ci.c_ses == 32'h0
         && ci.c_bbe == 32'h0)
      else $error("counts not cleared");
endmodule : psec_class
`default_nettype wire

// *** psec_monitor.sv ***
// Path error second monitor: anomaly and defect front end, two classifiers
`timescale 1ns/1ps
`default_nettype none
module psec_monitor
   import psec_pkg::*;
(
   input  wire logic          mclk,
   input  wire logic          rst_n,
   input  wire logic          sec_tick,
   input  wire logic          period_start,
   input  wire logic          cfg_cell,
   input  wire psec_vc_type   cfg_vc,
   input  wire psec_rate_type cfg_rate,
   input  wire logic          cfg_aggregate,
   input  wire logic          sdh_blk_valid,
   input  wire logic [7:0]    sdh_bip_syn,
   input  wire logic [5:0]    ne_path_def,
   input  wire logic          lp_rdi,
   input  wire logic          hp_rdi,
   input  wire logic          cell_valid,
   input  wire logic          cell_hdr_anom,
   input  wire logic          oam_valid,
   input  wire logic [63:0]   oam_bip_syn,
   input  wire logic          oam_hdr_corr,
   input  wire logic          oam_cec_err,
   input  wire logic          tp_ais,
   input  wire logic          cell_lcd,
   input  wire logic          sig_los,
   input  wire logic          tp_rdi,
   input  wire logic          rei_valid,
   input  wire logic [3:0]    rei_blocks,
   output logic [31:0]        ne_es_count,
   output logic [31:0]        ne_ses_count,
   output logic [31:0]        ne_bbe_count,
   output logic [31:0]        fe_es_count,
   output logic [31:0]        fe_ses_count,
   output logic [31:0]        fe_bbe_count,
   output logic               ne_es_sec,
   output logic               ne_ses_sec,
   output logic               fe_es_sec,
   output logic               fe_ses_sec,
   output logic               oam_loss2
);
   typedef struct packed {
      logic [8:0] cnt;
      logic [5:0] blk_cell;
      logic [2:0] blk_idx;
      logic [7:0] hdr_mask;
      logic       lost_once;
      logic       loss2;
   } psec_mon_st_type;

   psec_mon_st_type st_reg;
   psec_mon_st_type st_next;
   psec_class_if    ne_if ();
   psec_class_if    fe_if ();

   logic        lower;
   logic [5:0]  cpb;
   logic [3:0]  nblk;
   logic [8:0]  oam_x;
   logic [15:0] thr;
   logic [7:0]  valid_mask;
   logic [7:0]  bip_fail;
   logic [7:0]  last_blk;
   logic [7:0]  oam_mask;
   logic [7:0]  sdh_syn;
   logic        loss_evt;
   logic [3:0]  cell_inc;
   logic [3:0]  sdh_inc;
   logic        ne_defect;

   function automatic logic [3:0] psec_ones(input logic [7:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++) begin
         n = n + {3'h0, v[i]};
      end
      return n;
   endfunction : psec_ones

   // ===========================================================
   // Static path configuration
   assign lower = (cfg_vc == VC11) || (cfg_vc == VC12)
                  || (cfg_vc == VC2) || (cfg_vc == VC25C);

   always_comb begin
      unique case (cfg_rate)
         R155: begin
            cpb   = CPB_155;
            nblk  = NBLK_MULTI;
            oam_x = OAM_X_155;
            thr   = SES_THR_C155;
         end
         R622: begin
            cpb   = CPB_622;
            nblk  = NBLK_MULTI;
            oam_x = OAM_X_622;
            thr   = SES_THR_C622;
         end
         default: begin
            cpb   = CPB_51;
            nblk  = NBLK_ONE;
            oam_x = OAM_X_51;
            thr   = SES_THR_C51;
         end
      endcase
      if (!cfg_cell) begin
         thr = lower ? SES_THR_LOW : SES_THR_HIGH;
      end
   end

   // ===========================================================
   // SDH errored blocks from path parity
   assign sdh_syn = sdh_bip_syn & (lower ? BIP2_MASK : BIP8_MASK);
   assign sdh_inc = !sdh_blk_valid ? 4'h0 :
                    cfg_aggregate ? psec_ones(sdh_syn) :
                    {3'h0, |sdh_syn};

   // ===========================================================
   // Cell blocks, OAM monitoring and loss window
   assign valid_mask = (nblk == NBLK_ONE) ? 8'h01 : 8'hff;
   assign last_blk   = (nblk == NBLK_ONE) ? 8'h01 : 8'h80;
   assign loss_evt   = cfg_cell && cell_valid && !oam_valid
                       && (st_reg.cnt == oam_x);

   always_comb begin
      for (int b = 0; b < 8; b++) begin
         bip_fail[b] = |oam_bip_syn[8*b +: 8];
      end
      oam_mask = st_reg.hdr_mask | bip_fail;
      if (oam_hdr_corr) begin
         oam_mask = oam_mask | last_blk;
      end
      if (oam_cec_err) begin
         oam_mask = 8'hff;
      end
      oam_mask = oam_mask & valid_mask;
   end

   always_comb begin
      st_next  = st_reg;
      cell_inc = 4'h0;
      if (!cfg_cell) begin
         st_next = '0;
      end else if (oam_valid) begin
         cell_inc = psec_ones(oam_mask);
         st_next  = '0;
      end else if (loss_evt) begin
         cell_inc          = nblk;
         st_next.cnt       = 9'h0;
         st_next.blk_cell  = 6'h0;
         st_next.blk_idx   = 3'h0;
         st_next.hdr_mask  = 8'h0;
         st_next.lost_once = 1'b1;
         st_next.loss2     = st_reg.loss2 | st_reg.lost_once;
      end else if (cell_valid) begin
         st_next.cnt = st_reg.cnt + 9'h1;
         if (cell_hdr_anom) begin
            st_next.hdr_mask[st_reg.blk_idx] = 1'b1;
         end
         if (st_reg.blk_cell == cpb - 6'h1) begin
            st_next.blk_cell = 6'h0;
            if ({1'b0, st_reg.blk_idx} != nblk - 4'h1) begin
               st_next.blk_idx = st_reg.blk_idx + 3'h1;
            end
         end else begin
            st_next.blk_cell = st_reg.blk_cell + 6'h1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ===========================================================
   // Near-end and far-end defects and anomalies
   assign ne_defect = cfg_cell
      ? (st_reg.loss2 | tp_ais | cell_lcd | sig_los)
      : |(ne_path_def & (lower ? ND_LO_MASK : ND_HI_MASK));

   assign ne_if.tick   = sec_tick;
   assign ne_if.clear  = period_start;
   assign ne_if.hold   = 1'b0;
   assign ne_if.defect = ne_defect;
   assign ne_if.thr    = thr;
   assign ne_if.eb_inc = cfg_cell ? cell_inc : sdh_inc;

   assign fe_if.tick   = sec_tick;
   assign fe_if.clear  = period_start;
   assign fe_if.hold   = ne_if.def_now;
   assign fe_if.defect = cfg_cell ? tp_rdi :
                         (lower ? lp_rdi : hp_rdi);
   assign fe_if.thr    = thr;
   assign fe_if.eb_inc = rei_valid ? rei_blocks : 4'h0;

   psec_class u_ne (
      .mclk  (mclk),
      .rst_n (rst_n),
      .ci    (ne_if)
   );

   psec_class u_fe (
      .mclk  (mclk),
      .rst_n (rst_n),
      .ci    (fe_if)
   );

   assign ne_es_count  = ne_if.c_es;
   assign ne_ses_count = ne_if.c_ses;
   assign ne_bbe_count = ne_if.c_bbe;
   assign fe_es_count  = fe_if.c_es;
   assign fe_ses_count = fe_if.c_ses;
   assign fe_bbe_count = fe_if.c_bbe;
   assign ne_es_sec    = ne_if.es_p;
   assign ne_ses_sec   = ne_if.ses_p;
   assign fe_es_sec    = fe_if.es_p;
   assign fe_ses_sec   = fe_if.ses_p;
   assign oam_loss2    = st_reg.loss2;

   // ===========================================================
   // Checks
   sdh_thr_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !cfg_cell |-> thr == (lower ? 16'd600 : 16'd2400))
      else $error("wrong severe threshold");
   rdi_select_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !cfg_cell && !sec_tick && (lower ? lp_rdi : hp_rdi)
         |=> fe_if.def_now)
      else $error("path RDI not a far defect");
   bip_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !cfg_cell && !cfg_aggregate && sdh_blk_valid && sdh_syn != 8'h0
         |-> ne_if.eb_inc == 4'h1)
      else $error("parity check gave more than one block");
   oam_loss_a: assert property (@(posedge mclk) disable iff (!rst_n)
      loss_evt |-> ne_if.eb_inc == nblk ##1 st_reg.cnt == 9'h0)
      else $error("lost OAM cell did not error its blocks");
   loss_window_a: assert property (@(posedge mclk) disable iff (!rst_n)
      cfg_cell && cell_valid && !oam_valid && st_reg.cnt < oam_x
         |=> st_reg.cnt == $past(st_reg.cnt) + 9'h1)
      else $error("OAM loss declared early");
   loss_pair_a: assert property (@(posedge mclk) disable iff (!rst_n)
      loss_evt && st_reg.lost_once |=> oam_loss2 ##1 ne_if.def_now)
      else $error("second loss not a defect");
   far_continue_a: assert property (@(posedge mclk) disable iff (!rst_n)
      sec_tick && !period_start && !ne_if.def_now && rei_valid
         && rei_blocks != 4'h0 |=> fe_es_sec)
      else $error("far end not counted");
endmodule : psec_monitor
`default_nettype wire

// *** psec_framer_model.sv ***
// Receive framer model driving anomaly strobes and remote indications
`timescale 1ns/1ps
`default_nettype none
module psec_framer_model (
   input  wire logic   mclk,
   output logic        sdh_blk_valid,
   output logic [7:0]  sdh_bip_syn,
   output logic        cell_valid,
   output logic        cell_hdr_anom,
   output logic        oam_valid,
   output logic [63:0] oam_bip_syn,
   output logic        oam_hdr_corr,
   output logic        oam_cec_err,
   output logic        rei_valid,
   output logic [3:0]  rei_blocks
);
   // ==========================================================
   // Idle levels
   initial begin
      sdh_blk_valid = 1'b0;
      sdh_bip_syn   = 8'h00;
      cell_valid    = 1'b0;
      cell_hdr_anom = 1'b0;
      oam_valid     = 1'b0;
      oam_bip_syn   = 64'h0;
      oam_hdr_corr  = 1'b0;
      oam_cec_err   = 1'b0;
      rei_valid     = 1'b0;
      rei_blocks    = 4'h0;
   end
   // ==========================================================
   // Path parity checks, one block each
   task automatic sdh(input int n, input logic [7:0] syn);
      repeat (n) begin
         @(posedge mclk);
         #1;
         sdh_blk_valid = 1'b1;
         sdh_bip_syn   = syn;
      end
      @(posedge mclk);
      #1;
      sdh_blk_valid = 1'b0;
      sdh_bip_syn   = ~syn;
   endtask : sdh
   // ==========================================================
   // Non-OAM cells, the first na with header anomaly
   task automatic cells(input int n, input int na);
      for (int i = 0; i < n; i++) begin
         @(posedge mclk);
         #1;
         cell_valid    = 1'b1;
         cell_hdr_anom = (i < na);
      end
      @(posedge mclk);
      #1;
      cell_valid    = 1'b0;
      cell_hdr_anom = ~cell_hdr_anom;
   endtask : cells
   // ==========================================================
   // One OAM monitoring cell, never beside a plain cell
   task automatic oam(input logic [63:0] syn, input logic hc, input logic ce);
      @(posedge mclk);
      #1;
      oam_valid    = 1'b1;
      oam_bip_syn  = syn;
      oam_hdr_corr = hc;
      oam_cec_err  = ce;
      @(posedge mclk);
      #1;
      oam_valid    = 1'b0;
      oam_bip_syn  = ~syn;
      oam_hdr_corr = ~hc;
      oam_cec_err  = ~ce;
   endtask : oam
   // ==========================================================
   // Remote error indication
   task automatic rei(input logic [3:0] k);
      @(posedge mclk);
      #1;
      rei_valid  = 1'b1;
      rei_blocks = k;
      @(posedge mclk);
      #1;
      rei_valid  = 1'b0;
      rei_blocks = ~k;
   endtask : rei
endmodule : psec_framer_model
`default_nettype wire

// *** test_path_error_second_classifier.sv ***
// Self-checking bench of the path error second monitor
`timescale 1ns/1ps
`default_nettype none
module test_path_error_second_classifier
   import psec_pkg::*;
;
   typedef struct {
      psec_vc_type vc;
      logic        agg;
      int          nb;
      logic [7:0]  syn;
      logic [5:0]  nd;
      logic [1:0]  rdi;
      int          rei;
      logic [3:0]  ev;
      int          nbbe;
      int          fbbe;
   } psec_row_type;
   logic mclk, rst_n, sec_tick, period_start, cfg_cell, cfg_aggregate;
   psec_vc_type   cfg_vc;
   psec_rate_type cfg_rate;
   logic [5:0]    ne_path_def;
   logic [1:0]    rdi;
   logic [2:0]    cdef;
   logic          tp_rdi, oam_loss2;
   logic          sbv, cv, cha, ov, ohc, oce, rv;
   logic [7:0]    ssyn;
   logic [63:0]   osyn;
   logic [3:0]    rblk;
   logic [31:0]   cnt [6];
   logic [3:0]    sec;
   logic [31:0]   exp [6];
   int            n_mismatch;
   int            checks;
   // Ordinary seconds: ev is ne_es, ne_ses, fe_es, fe_ses
   psec_row_type rows [20] = '{
      '{VC12, 1'b0, 1, 8'h01, 6'h00, 2'b00, 0, 4'b1000, 1, 0},
      '{VC12, 1'b0, 599, 8'h02, 6'h00, 2'b00, 0, 4'b1000, 599, 0},
      '{VC12, 1'b0, 600, 8'h03, 6'h00, 2'b00, 0, 4'b1100, 0, 0},
      '{VC11, 1'b0, 600, 8'h01, 6'h00, 2'b00, 0, 4'b1100, 0, 0},
      '{VC2, 1'b0, 600, 8'h01, 6'h00, 2'b00, 0, 4'b1100, 0, 0},
      '{VC3, 1'b0, 2399, 8'h10, 6'h00, 2'b00, 0, 4'b1000, 2399, 0},
      '{VC4, 1'b0, 2399, 8'hff, 6'h00, 2'b00, 0, 4'b1000, 2399, 0},
      '{VC44C, 1'b0, 2400, 8'h80, 6'h00, 2'b00, 0, 4'b1100, 0, 0},
      '{VC12, 1'b0, 5, 8'hfc, 6'h00, 2'b00, 0, 4'b0000, 0, 0},
      '{VC12, 1'b1, 300, 8'h03, 6'h00, 2'b00, 0, 4'b1100, 0, 0},
      '{VC3, 1'b1, 1, 8'h0f, 6'h00, 2'b00, 0, 4'b1000, 4, 0},
      '{VC12, 1'b0, 0, 8'h00, 6'h01, 2'b00, 5, 4'b1100, 0, 0},
      '{VC12, 1'b0, 600, 8'h01, 6'h00, 2'b00, 3, 4'b1110, 0, 3},
      '{VC12, 1'b0, 0, 8'h00, 6'h00, 2'b10, 0, 4'b0011, 0, 0},
      '{VC4, 1'b0, 0, 8'h00, 6'h00, 2'b10, 0, 4'b0000, 0, 0},
      '{VC4, 1'b0, 0, 8'h00, 6'h00, 2'b01, 0, 4'b0011, 0, 0},
      '{VC4, 1'b0, 0, 8'h00, 6'h00, 2'b00, 7, 4'b0010, 0, 7},
      '{VC4, 1'b0, 0, 8'h00, 6'h20, 2'b00, 0, 4'b1100, 0, 0},
      '{VC2, 1'b0, 0, 8'h00, 6'h10, 2'b00, 0, 4'b0000, 0, 0},
      '{VC25C, 1'b0, 0, 8'h00, 6'h08, 2'b00, 0, 4'b1100, 0, 0}};
   // ==========================================================
   // Design and framer model
   psec_monitor dut (.mclk(mclk), .rst_n(rst_n), .sec_tick(sec_tick),
      .period_start(period_start), .cfg_cell(cfg_cell), .cfg_vc(cfg_vc),
      .cfg_rate(cfg_rate), .cfg_aggregate(cfg_aggregate),
      .sdh_blk_valid(sbv), .sdh_bip_syn(ssyn), .ne_path_def(ne_path_def),
      .lp_rdi(rdi[1]), .hp_rdi(rdi[0]), .cell_valid(cv),
      .cell_hdr_anom(cha), .oam_valid(ov), .oam_bip_syn(osyn),
      .oam_hdr_corr(ohc), .oam_cec_err(oce), .tp_ais(cdef[0]),
      .cell_lcd(cdef[1]), .sig_los(cdef[2]), .tp_rdi(tp_rdi),
      .rei_valid(rv), .rei_blocks(rblk), .ne_es_count(cnt[0]),
      .ne_ses_count(cnt[1]), .ne_bbe_count(cnt[2]), .fe_es_count(cnt[3]),
      .fe_ses_count(cnt[4]), .fe_bbe_count(cnt[5]), .ne_es_sec(sec[3]),
      .ne_ses_sec(sec[2]), .fe_es_sec(sec[1]), .fe_ses_sec(sec[0]),
      .oam_loss2(oam_loss2));
   psec_framer_model model (.mclk(mclk), .sdh_blk_valid(sbv),
      .sdh_bip_syn(ssyn), .cell_valid(cv), .cell_hdr_anom(cha),
      .oam_valid(ov), .oam_bip_syn(osyn), .oam_hdr_corr(ohc),
      .oam_cec_err(oce), .rei_valid(rv), .rei_blocks(rblk));
   always #4 mclk = ~mclk;
   // ==========================================================
   // Checking tasks
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic chk_all();
      for (int i = 0; i < 6; i++) begin
         chk($sformatf("count %0d", i), exp[i], cnt[i]);
      end
   endtask : chk_all
   task automatic close_sec(input logic [3:0] ev, input int nb, input int fb);
      @(posedge mclk);
      #1;
      sec_tick = 1'b1;
      @(posedge mclk);
      #1;
      sec_tick = 1'b0;
      exp[0] += ev[3];
      exp[1] += ev[2];
      exp[2] += nb;
      exp[3] += ev[1];
      exp[4] += ev[0];
      exp[5] += fb;
      chk("second pulses", {28'h0, ev}, {28'h0, sec});
      chk_all();
      @(posedge mclk);
      #1;
      chk("pulses after", 32'h0, {28'h0, sec});
   endtask : close_sec
   task automatic clear_period(input logic t);
      @(posedge mclk);
      #1;
      sec_tick     = t;
      period_start = 1'b1;
      @(posedge mclk);
      #1;
      sec_tick     = 1'b0;
      period_start = 1'b0;
      exp = '{default: 32'h0};
      chk("pulses on clear", 32'h0, {28'h0, sec});
      chk_all();
   endtask : clear_period
   task automatic print_verdict();
      $display("Comparisons %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end
      else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict
   // ==========================================================
   // Watchdog
   initial begin
      repeat (100000) @(posedge mclk);
      n_mismatch++;
      print_verdict();
   end
   // ==========================================================
   // Main sequence
   initial begin
      mclk = 1'b0;
      rst_n = 1'b0;
      {sec_tick, period_start, cfg_cell, cfg_aggregate, tp_rdi} = 5'h0;
      cfg_vc = VC12;
      cfg_rate = R51;
      ne_path_def = 6'h00;
      rdi = 2'b00;
      cdef = 3'b000;
      n_mismatch = 0;
      checks = 0;
      exp = '{default: 32'h0};
      repeat (16) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      chk_all();
      chk("loss after reset", 32'h0, {31'h0, oam_loss2});
      foreach (rows[i]) begin
         cfg_vc = rows[i].vc;
         cfg_aggregate = rows[i].agg;
         ne_path_def = rows[i].nd;
         rdi = rows[i].rdi;
         model.sdh(rows[i].nb, rows[i].syn);
         ne_path_def = 6'h00;
         rdi = 2'b00;
         if (rows[i].rei > 0) begin
            model.rei(rows[i].rei[3:0]);
         end
         close_sec(rows[i].ev, rows[i].nbbe, rows[i].fbbe);
      end
      model.sdh(600, 8'h01);
      fork
         model.rei(4'h2);
         close_sec(4'b1110, 0, 2);
      join
      model.sdh(3, 8'h01);
      clear_period(1'b1);
      cfg_cell = 1'b1;
      model.oam(64'h0, 1'b0, 1'b0);
      close_sec(4'b0000, 0, 0);
      model.cells(14, 2);
      model.oam(64'h1, 1'b0, 1'b0);
      close_sec(4'b1000, 1, 0);
      cfg_rate = R155;
      model.cells(215, 0);
      model.oam(64'h8000_0000_0000_0001, 1'b0, 1'b0);
      close_sec(4'b1000, 2, 0);
      model.cells(215, 0);
      model.oam(64'h0, 1'b0, 1'b1);
      close_sec(4'b1000, 8, 0);
      model.cells(215, 0);
      model.oam(64'h0, 1'b1, 1'b0);
      close_sec(4'b1000, 1, 0);
      cfg_rate = R622;
      model.cells(431, 0);
      model.oam(64'h0, 1'b0, 1'b1);
      close_sec(4'b1000, 8, 0);
      cfg_rate = R51;
      model.cells(30, 0);
      @(posedge mclk);
      #1;
      chk("double loss", 32'h1, {31'h0, oam_loss2});
      model.oam(64'h0, 1'b0, 1'b0);
      @(posedge mclk);
      #1;
      chk("loss cleared", 32'h0, {31'h0, oam_loss2});
      close_sec(4'b1100, 0, 0);
      for (int i = 0; i < 3; i++) begin
         cdef = 3'b001 << i;
         @(posedge mclk);
         #1;
         cdef = 3'b000;
         close_sec(4'b1100, 0, 0);
      end
      // ==========================================================
      // Reset in mid-run with counts and loss defect set
      model.cells(30, 0);
      chk("double loss", 32'h1, {31'h0, oam_loss2});
      rst_n = 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      exp = '{default: 32'h0};
      chk_all();
      chk("loss after reset", 32'h0, {31'h0, oam_loss2});
      chk("pulses after reset", 32'h0, {28'h0, sec});
      tp_rdi = 1'b1;
      @(posedge mclk);
      #1;
      tp_rdi = 1'b0;
      close_sec(4'b0011, 0, 0);
      clear_period(1'b0);
      print_verdict();
   end
endmodule : test_path_error_second_classifier
`default_nettype wire
